/* rtl/sea_pkg.sv */
/*
  Shared constants and types for the serial EEPROM access logic: slave
  address layout, memory geometry, bit slot numbers, write cycle timing,
  protocol states and the packed carriers between the pin front end and
  the command logic.
  Assumes a 20 MHz system clock and a separate, faster-than-SCL link
  clock that oversamples the two-wire bus pins.
*/
package sea_pkg;

  // fixed upper nibble of the slave address
  localparam logic [3:0] DEV_TYPE      = 4'hA;
  // select bits taken as upper memory address (0 to 3)
  localparam int         SEL_ADDR_BITS = 1;
  localparam int         WORD_W        = 8;
  localparam int         PTR_W         = WORD_W + SEL_ADDR_BITS;
  localparam int         MEM_BYTES     = 1 << PTR_W;
  localparam int         PAGE_W        = 4;
  localparam int         PAGE_BYTES    = 1 << PAGE_W;
  localparam logic [7:0] ERASED        = 8'hFF;

  // bit slot counter: 0..7 data bits, 8 ack slot, 9 ack held
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // internal_write_cycle_time
  localparam int WR_TIME_NS   = 5000000;
  localparam int CLK_NS       = 50;
  localparam int WR_CYCLES    = WR_TIME_NS / CLK_NS;
  localparam int WRC_W        = 24;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEV    = 3'b001,
    ST_WORD   = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_IGNORE = 3'b101
  } sea_state_e;

  // bus events, one link clock wide
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } sea_ev_s;

  // synchronised static pins
  typedef struct packed {
    logic [2:0] sel;
    logic       wp;
  } sea_strap_s;

endpackage

/* rtl/sea_pin_sync.sv */
/*
  Pin front end of the serial EEPROM access logic: two-flop
  synchronisers for the bus lines and static pins, and detection of
  START, STOP and clock edges on the link clock.
  Assumes the link clock runs freely and samples SCL at least three
  times in each SCL high and low phase.
*/
`timescale 1ns/10ps
`default_nettype none

module sea_pin_sync (
  input  wire logic              link_clk,
  input  wire logic              link_rst,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic [2:0]        sel_in,
  input  wire logic              wp_in,
  output sea_pkg::sea_ev_s       ev,
  output sea_pkg::sea_strap_s    strap
);

  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;
  logic [3:0] strap_meta_q;
  logic       scl_s_q;
  logic       sda_s_q;
  logic       scl_p_q;
  logic       sda_p_q;

  // first stages feed only the second stages
  always_ff @(posedge link_clk) begin
    scl_meta_q   <= {scl_meta_q[0], scl_in};
    sda_meta_q   <= {sda_meta_q[0], sda_in};
    strap_meta_q <= {sel_in, wp_in};
    strap        <= strap_meta_q;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= scl_meta_q[1];
      sda_s_q <= sda_meta_q[1];
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // data line moving while clock high marks START or STOP
  always_comb begin
    ev.start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    ev.stop  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    ev.rise  = scl_s_q && !scl_p_q;
    ev.fall  = !scl_s_q && scl_p_q;
    ev.sda   = sda_s_q;
  end

endmodule // sea_pin_sync

`default_nettype wire

/* rtl/sea_top.sv */
/*
  Serial EEPROM access logic: two-wire slave command handling, page
  buffer, memory array, write protection and the timed internal write
  cycle with acknowledge polling.
  Assumes a free running link clock that oversamples SCL and SDA, and a
  20 MHz system clock that times the internal write cycle.
*/
// How it works
// - slave address must start with 1010
// - select bits match pins or become address
// - acknowledge by pulling data low, ninth clock
// - first written byte loads the address pointer
// - ack data bytes, write cycle starts at STOP
// - busy writing: release data, ignore everything
// - page write holds up to sixteen bytes
// - writes step only the four low bits
// - extra bytes wrap inside page, overwrite earlier
// - STOP commits all buffered bytes in one cycle
// - poll address gets NoACK busy, ACK after
// - protect pin high blocks all writes
// - protect sampled before first data, NoACK it
// - memory starts with every byte FFh
// - read address acked, current byte shifted out
// - NoACK then STOP ends read, idle
// - random read via dummy write, repeated START
// - master ack keeps successive bytes coming
// - read counter crosses pages, wraps at end
// - smallest variant read counter never wraps early
`timescale 1ns/10ps
`default_nettype none

module sea_top #(
  parameter int WR_CYCLES = sea_pkg::WR_CYCLES
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic link_clk,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  input  wire logic chip_select_pin_0,
  input  wire logic chip_select_pin_1,
  input  wire logic chip_select_pin_2,
  input  wire logic write_protect,
  output var  logic write_busy
);

  typedef logic [sea_pkg::PTR_W-1:0] sea_ptr_t;

  // full-width step: reads cross pages, wrap only at the top
  function automatic sea_ptr_t ptr_next(input sea_ptr_t p);
    return p + sea_pkg::PTR_W'(1);
  endfunction

  // in-page step for writes; page select bits untouched
  function automatic sea_ptr_t ptr_page_next(input sea_ptr_t p);
    sea_ptr_t n;
    n = p;
    n[sea_pkg::PAGE_W-1:0] = p[sea_pkg::PAGE_W-1:0] + sea_pkg::PAGE_W'(1);
    return n;
  endfunction

  // a data bit arrives on a rise while slots 0..7 are open
  function automatic logic data_slot(input logic       rise,
                                     input logic [3:0] slot);
    return rise && (slot < sea_pkg::BIT_ACK);
  endfunction

  // address nibble and select pins against received slave address
  function automatic logic sel_match(input logic [7:0] b,
                                     input logic [2:0] pins);
    logic m;
    m = (b[7:4] == sea_pkg::DEV_TYPE);
    for (int i = sea_pkg::SEL_ADDR_BITS; i < 3; i++) begin
      m = m && (b[i+1] == pins[i]);
    end
    return m;
  endfunction

  // link domain reset, taken from the system reset level
  logic [1:0] link_rst_meta_q;
  logic       link_rst;

  always_ff @(posedge link_clk) begin
    link_rst_meta_q <= {link_rst_meta_q[0], sys_rst};
  end
  assign link_rst = link_rst_meta_q[1];

  sea_pkg::sea_ev_s    ev;
  sea_pkg::sea_strap_s strap;

  sea_pin_sync u_pins (
    .link_clk (link_clk),
    .link_rst (link_rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sel_in   ({chip_select_pin_2, chip_select_pin_1, chip_select_pin_0}),
    .wp_in    (write_protect),
    .ev       (ev),
    .strap    (strap)
  );

  // link domain state
  sea_pkg::sea_state_e state_q;
  logic [3:0]          bit_q;
  logic [7:0]          shreg_q;
  logic [7:0]          tx_q;
  logic                rw_q;
  logic                mack_q;
  logic                wp_block_q;
  logic                wrote_q;
  logic                busy_q;
  logic                req_tgl_q;
  logic                oe_q;
  sea_ptr_t            ptr_q;
  // delivered state: fully erased, kept across resets
  logic [7:0]          mem [sea_pkg::MEM_BYTES]
                         = '{default: sea_pkg::ERASED};
  logic [7:0]          pg_buf [sea_pkg::PAGE_BYTES];
  logic [sea_pkg::PAGE_BYTES-1:0] pg_mask_q;

  logic [2:0] done_sync_q;
  logic       done_pulse;
  logic       byte_done;
  logic       ack_end;
  logic       pg_wr;
  logic       commit;
  logic       addr_hit;
  logic [7:0] rd_byte;
  // toggled on mclk at the end of each cycle, synced in below
  logic       done_tgl_q;

  assign done_pulse = done_sync_q[1] ^ done_sync_q[2];
  assign rd_byte    = mem[ptr_q];

  always_comb begin
    byte_done = ev.fall && (bit_q == sea_pkg::BIT_ACK);
    ack_end   = ev.fall && (bit_q == sea_pkg::BIT_END);
    addr_hit  = sel_match(shreg_q, strap.sel);
    pg_wr     = (state_q == sea_pkg::ST_WDATA) && byte_done
                && !wp_block_q;
    commit    = ev.stop && wrote_q;
  end

  // protocol engine
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_q    <= sea_pkg::ST_IDLE;
      bit_q      <= 4'h0;
      shreg_q    <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      mack_q     <= 1'b0;
      wp_block_q <= 1'b0;
      wrote_q    <= 1'b0;
      oe_q       <= 1'b0;
      ptr_q      <= '0;
    end else if (ev.start) begin
      // repeated START abandons unwritten data
      bit_q   <= 4'h0;
      oe_q    <= 1'b0;
      wrote_q <= 1'b0;
      state_q <= busy_q ? sea_pkg::ST_IGNORE : sea_pkg::ST_DEV;
    end else if (ev.stop) begin
      bit_q   <= 4'h0;
      oe_q    <= 1'b0;
      wrote_q <= 1'b0;
      state_q <= sea_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sea_pkg::ST_DEV,
        sea_pkg::ST_WORD,
        sea_pkg::ST_WDATA: begin
          if (data_slot(ev.rise, bit_q)) begin
            shreg_q <= {shreg_q[6:0], ev.sda};
            bit_q   <= bit_q + sea_pkg::BIT_ONE;
          end else if (byte_done) begin
            bit_q <= sea_pkg::BIT_END;
            if (state_q == sea_pkg::ST_DEV) begin
              if (addr_hit) begin
                oe_q  <= 1'b1;
                rw_q  <= shreg_q[0];
                ptr_q[sea_pkg::PTR_W-1:sea_pkg::WORD_W]
                      <= shreg_q[sea_pkg::SEL_ADDR_BITS:1];
              end else begin
                state_q <= sea_pkg::ST_IGNORE;
              end
            end else if (state_q == sea_pkg::ST_WORD) begin
              oe_q <= 1'b1;
              ptr_q[sea_pkg::WORD_W-1:0] <= shreg_q;
            end else if (wp_block_q) begin
              state_q <= sea_pkg::ST_IGNORE;
            end else begin
              oe_q    <= 1'b1;
              wrote_q <= 1'b1;
              // low four bits only, wrap inside page
              ptr_q   <= ptr_page_next(ptr_q);
            end
          end else if (ack_end) begin
            bit_q <= 4'h0;
            if (state_q == sea_pkg::ST_DEV && rw_q) begin
              state_q <= sea_pkg::ST_RDATA;
              tx_q    <= rd_byte;
              oe_q    <= !rd_byte[7];
              ptr_q   <= ptr_next(ptr_q);
            end else begin
              oe_q <= 1'b0;
              if (state_q == sea_pkg::ST_DEV) begin
                state_q <= sea_pkg::ST_WORD;
              end else if (state_q == sea_pkg::ST_WORD) begin
                state_q    <= sea_pkg::ST_WDATA;
                // strobe on the fall just before the first data bit
                wp_block_q <= strap.wp;
              end
            end
          end
        end
        sea_pkg::ST_RDATA: begin
          if (data_slot(ev.rise, bit_q)) begin
            bit_q <= bit_q + sea_pkg::BIT_ONE;
          end else if (ev.rise && bit_q == sea_pkg::BIT_ACK) begin
            mack_q <= !ev.sda;
            bit_q  <= sea_pkg::BIT_END;
          end else if (ev.fall && bit_q >= sea_pkg::BIT_ONE
                       && bit_q < sea_pkg::BIT_ACK) begin
            oe_q <= !tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end else if (byte_done) begin
            oe_q <= 1'b0; // release for the master's answer
          end else if (ack_end) begin
            bit_q <= 4'h0;
            if (mack_q) begin
              tx_q  <= rd_byte;
              oe_q  <= !rd_byte[7];
              ptr_q <= ptr_next(ptr_q);
            end else begin
              state_q <= sea_pkg::ST_IGNORE;
            end
          end
        end
        sea_pkg::ST_IGNORE: begin
          oe_q <= 1'b0;
        end
        sea_pkg::ST_IDLE: begin
          oe_q <= 1'b0;
        end
        default: begin
          state_q <= sea_pkg::ST_IDLE;
          oe_q    <= 1'b0;
        end
      endcase
    end
  end

  // sda never drives high; open drain through the enable only
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= oe_q && !busy_q;
    end
  end

  // page buffer and commit of the buffered bytes together
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      pg_mask_q <= '0;
    end else if (commit) begin
      for (int i = 0; i < sea_pkg::PAGE_BYTES; i++) begin
        if (pg_mask_q[i]) begin
          mem[{ptr_q[sea_pkg::PTR_W-1:sea_pkg::PAGE_W],
               sea_pkg::PAGE_W'(i)}] <= pg_buf[i];
        end
      end
      pg_mask_q <= '0;
    end else if (ev.start) begin
      pg_mask_q <= '0;
    end else if (pg_wr) begin
      pg_buf[ptr_q[sea_pkg::PAGE_W-1:0]]    <= shreg_q;
      pg_mask_q[ptr_q[sea_pkg::PAGE_W-1:0]] <= 1'b1;
    end
  end

  // busy flag and request toggle toward the timer
  // set wins over clear: a fresh commit outranks a late done
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      busy_q      <= 1'b0;
      req_tgl_q   <= 1'b0;
      done_sync_q <= 3'b000;
    end else begin
      done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      if (commit) begin
        busy_q    <= 1'b1;
        req_tgl_q <= !req_tgl_q;
      end else if (done_pulse) begin
        busy_q <= 1'b0;
      end
    end
  end

  // system clock side: times the internal write cycle
  // timed on mclk so the cycle length is independent of link rate
  logic [2:0]                req_sync_q;
  logic [sea_pkg::WRC_W-1:0] wr_cnt_q;
  logic                      req_pulse;

  assign req_pulse = req_sync_q[1] ^ req_sync_q[2];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_sync_q <= 3'b000;
    end else begin
      req_sync_q <= {req_sync_q[1:0], req_tgl_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_cnt_q   <= '0;
      write_busy <= 1'b0;
      done_tgl_q <= 1'b0;
    end else if (req_pulse) begin
      wr_cnt_q   <= sea_pkg::WRC_W'(WR_CYCLES - 1);
      write_busy <= 1'b1;
    end else if (write_busy) begin
      if (wr_cnt_q == '0) begin
        write_busy <= 1'b0;
        done_tgl_q <= !done_tgl_q;
      end else begin
        wr_cnt_q <= wr_cnt_q - sea_pkg::WRC_W'(1);
      end
    end
  end

endmodule // sea_top

`default_nettype wire

/* bench/sea_chk.sv */
/*
  Assertion checker for the serial EEPROM access logic top level.
  Assumes it is bound to sea_top and that mclk runs well above SCL.
*/
`timescale 1ns/10ps
`default_nettype none

module sea_chk #(
  parameter int WR_CYCLES = 400
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic write_busy
);
  logic        scl_q;
  logic        sda_q;
  logic        stop_p;
  logic [15:0] busy_q;
  logic [10:0] wp_q;
  logic [7:0]  since_q;

  // raw pin stop, ahead of the design's synchronised view
  assign stop_p = scl_in && scl_q && sda_in && !sda_q;

  always_ff @(posedge mclk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || !write_busy) busy_q <= '0;
    else busy_q <= busy_q + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || !write_protect) wp_q <= '0;
    else if (wp_q != 11'h7FF) wp_q <= wp_q + 11'h001;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || stop_p) since_q <= '0;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end

  property p_out_low;
    @(posedge mclk) disable iff (sys_rst) !sda_out;
  endproperty
  a_out_low: assert property (p_out_low) else $error("data value high");
  property p_oe_edge;
    @(posedge link_clk) disable iff (sys_rst) $rose(sda_oe) |-> !scl_in;
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("drive in scl high");
  property p_oe_hold;
    @(posedge link_clk) disable iff (sys_rst)
      scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved");
  property p_busy_quiet;
    @(posedge mclk) disable iff (sys_rst) write_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy drive");
  property p_busy_len;
    @(posedge mclk) disable iff (sys_rst)
      $fell(write_busy) |-> int'(busy_q) == WR_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_busy_stop;
    @(posedge mclk) disable iff (sys_rst)
      $rose(write_busy) |-> since_q < 8'h40;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("busy no stop");
  property p_wp_block;
    @(posedge mclk) disable iff (sys_rst) $rose(write_busy) |-> wp_q < 11'h3E8;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write while wp");
  property p_stop_idle;
    @(posedge mclk) disable iff (sys_rst) stop_p |-> (!sda_oe) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("drive at stop");

  c_busy: cover property (@(posedge mclk) $rose(write_busy));
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
  c_stop: cover property (@(posedge mclk) stop_p);
endmodule // sea_chk

bind sea_top sea_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (.mclk, .sys_rst,
  .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .write_protect,
  .write_busy);

`default_nettype wire

/* bench/sea_tb_master.sv */
/*
  Two-wire bus master model issuing start, stop, byte writes and reads.
  Assumes a pulled-up data wire resolved outside; pull high = drive low.
*/
`timescale 1ns/10ps
`default_nettype none

module sea_tb_master (
  input  wire logic       mclk,
  input  wire logic       sda_in,
  output var  logic       scl,
  output var  logic       pull,
  output var  logic [8:0] res
);
  event got;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
    res = '0;
  end

  task automatic hp(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // data held 4 cycles past scl fall so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    hp(16);
    scl = 1'b1;
    hp(16);
    r = sda_in;
    scl = 1'b0;
    hp(4);
  endtask

  task automatic start();
    pull = 1'b0;
    hp(16);
    scl = 1'b1;
    hp(16);
    pull = 1'b1;
    hp(16);
    scl = 1'b0;
    hp(4);
  endtask

  task automatic stop();
    pull = 1'b1;
    hp(16);
    scl = 1'b1;
    hp(16);
    pull = 1'b0;
    hp(16);
  endtask

  task automatic wr_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    res = {1'b1, 7'h00, !r};
    ->got;
  endtask

  task automatic rd_byte(input logic ack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
    res = {1'b0, d};
    ->got;
  endtask
endmodule // sea_tb_master

`default_nettype wire

/* bench/tb_top.sv */
/*
  Self-checking bench for the serial EEPROM access logic.
  Assumes sea_top, its checker bind and the bus master model.
*/
`timescale 1ns/10ps
`default_nettype none
`define CMP(e, a) begin compares++; if ((e) !== (a)) begin error_cnt++; \
  $display("MISMATCH t=%0t exp=%h got=%h", $time, (e), (a)); end end

module tb_top;
  logic       mclk = 1'b0;
  logic       link_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       wp = 1'b0;
  logic [2:0] pins = 3'h0;
  logic       sda_oe;
  logic       write_busy;
  logic       scl;
  logic       pull;
  wire        sda_w = !(pull || sda_oe);
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  logic [8:0] exp_q[$];
  logic [8:0] exp_v;
  logic [7:0] mem[512];
  logic [8:0] ptr;
  logic [8:0] a;

  always #25 mclk = !mclk;
  initial begin
    #3;
    forever #80 link_clk = !link_clk;
  end

  sea_top #(.WR_CYCLES(400)) dut (.mclk, .sys_rst, .link_clk, .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe, .chip_select_pin_0(pins[0]),
    .chip_select_pin_1(pins[1]), .chip_select_pin_2(pins[2]),
    .write_protect(wp), .write_busy);
  sea_tb_master m (.mclk, .sda_in(sda_w), .scl, .pull, .res());

  always @(m.got) begin
    exp_v = exp_q.pop_front();
    `CMP(exp_v, m.res)
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [7:0] dev(input logic rw, input logic [8:0] p);
    return {4'hA, pins[2:1], p[8], rw};
  endfunction

  task automatic wb(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    m.wr_byte(b);
  endtask

  task automatic set_ptr(input logic [8:0] p);
    m.start();
    wb(dev(1'b0, p), 1'b1);
    wb(p[7:0], 1'b1);
    ptr = p;
  endtask

  // current-address read; master acks all but the last byte
  task automatic rd(input int n);
    m.start();
    wb(dev(1'b1, ptr), 1'b1);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, mem[ptr]});
      ptr = ptr + 9'h001;
      m.rd_byte(i < n - 1);
    end
    m.stop();
  endtask

  task automatic wr(input logic [8:0] p, input int n);
    logic [7:0] d;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wb(d, !wp);
      if (!wp) begin
        mem[ptr] = d;
        ptr[3:0] = ptr[3:0] + 4'h1;
      end
    end
    m.stop();
  endtask

  // first poll lands inside the write cycle, second after it
  task automatic poll();
    m.start();
    `CMP(1'b1, write_busy)
    wb(dev(1'b0, ptr), 1'b0);
    m.stop();
    m.start();
    wb(dev(1'b0, ptr), 1'b1);
    m.stop();
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    void'($urandom(56591));
    repeat (20) @(negedge mclk);
    pins = 3'($urandom);
    sys_rst = 1'b0;
    m.hp(40);
    set_ptr(9'($urandom));
    rd(2);
    done("erased");
    m.start();
    wb({4'hB, pins[2:1], 2'b00}, 1'b0);
    m.stop();
    m.start();
    wb({4'hA, ~pins[2:1], 2'b00}, 1'b0);
    m.stop();
    done("address");
    a = {5'($urandom), 4'hE};
    wr(a, 18);
    poll();
    rd(1);
    set_ptr({a[8:4], 4'h0});
    rd(17);
    done("page");
    a = 9'($urandom);
    for (int k = 1; k >= 0; k--) begin
      wp = k[0];
      wr(a, 1);
      m.hp(40);
      `CMP(!wp, write_busy)
      if (!wp) poll();
      set_ptr(a);
      rd(1);
    end
    done("protect");
    set_ptr(9'h1FF);
    rd(2);
    set_ptr(a + 9'h011);
    m.stop();
    m.hp(40);
    `CMP(1'b0, write_busy)
    rd(1);
    done("pointer");
    m.hp(20);
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
